//--- core/cimr_crc7.sv
// Bit-serial 7-bit checksum engine for the identification word.
// Assumes the caller clears it, then shifts one bit per cycle, most significant first.
`default_nettype none

module cimr_crc7
  import cimr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic       clear_in,
  input  wire logic       shift_in,
  input  wire logic       bit_in,
  output logic      [6:0] crc_out
);

  typedef struct packed {
    logic [6:0] crc;
  } cimr_crc_regs_t;

  cimr_crc_regs_t st_reg;
  cimr_crc_regs_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (clear_in)
    begin
      st_next.crc = 7'h00;
    end
    else if (shift_in)
    begin
      st_next.crc = cimr_crc7_step(st_reg.crc, bit_in);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign crc_out = st_reg.crc;

endmodule : cimr_crc7

`default_nettype wire

//--- core/cimr_pkg.sv
// Constants, field layouts and helpers for the card identity register bank.
// Assumes a single 200 MHz clock domain and an active-low asynchronous reset.
`default_nettype none

package cimr_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MCLK_PERIOD_NS  = 5;
  localparam int POWERUP_TIME_NS = 1000;
  // Least time, so round up to whole cycles
  localparam int POWERUP_CYC_INT = (POWERUP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int TIMER_W         = 16;
  localparam logic [TIMER_W-1:0] POWERUP_CYC = TIMER_W'(POWERUP_CYC_INT);

  // ****************************************************************
  // Operating-conditions word
  // ****************************************************************
  localparam int         OCR_BUSY_BIT    = 31;
  localparam logic [1:0] OCR_ACCESS_SECT = 2'h2;
  localparam logic [4:0] OCR_RSVD_HI     = 5'h00;
  localparam logic [8:0] OCR_VCCQ_HIGH   = 9'h1ff;
  localparam logic [6:0] OCR_VCCQ_MID    = 7'h00;
  localparam logic       OCR_VCCQ_LOW    = 1'b1;
  localparam logic [6:0] OCR_RSVD_LO     = 7'h00;
  localparam logic [31:0] OCR_RESET =
    {1'b0, OCR_ACCESS_SECT, OCR_RSVD_HI, OCR_VCCQ_HIGH, OCR_VCCQ_MID, OCR_VCCQ_LOW, OCR_RSVD_LO};

  // ****************************************************************
  // Identification word (identity values are arbitrary)
  // ****************************************************************
  localparam logic [7:0]  CID_MAKER_CODE   = 8'h5a;
  localparam logic [5:0]  CID_RSVD         = 6'h00;
  localparam logic [1:0]  CID_PACKAGE_TYPE = 2'h2;
  localparam logic [7:0]  CID_OEM_CODE     = 8'h3c;
  localparam logic [47:0] CID_PRODUCT_NAME = 48'h434d_5230_3031;
  localparam logic [7:0]  CID_PRODUCT_REV  = 8'h11;
  localparam int          CID_BODY_BITS    = 120;
  localparam logic [6:0]  CID_LAST_IDX     = 7'h77;
  localparam logic [127:0] CID_RESET =
    {CID_MAKER_CODE, CID_RSVD, CID_PACKAGE_TYPE, CID_OEM_CODE, CID_PRODUCT_NAME,
     CID_PRODUCT_REV, 32'h0000_0000, 8'h00, 7'h00, 1'b1};

  // ****************************************************************
  // Card-specific data word
  // ****************************************************************
  localparam logic [1:0]  STRUCTURE_VERSION_VER = 2'h3;
  localparam logic [3:0]  CSD_SPEC_VER      = 4'h4;
  localparam logic [7:0]  CSD_ACCESS_NS     = 8'h4f;
  localparam logic [7:0]  CSD_ACCESS_CLK    = 8'h01;
  localparam logic [7:0]  CSD_BUS_CLOCK     = 8'h32;
  localparam logic [11:0] CSD_CMD_CLASSES   = 12'h0f5;
  localparam logic [3:0]  CSD_BLOCK_LEN     = 4'h9;
  localparam logic [11:0] CSD_DEVICE_SIZE   = 12'hfff;
  localparam logic [2:0]  CSD_CURRENT_CODE  = 3'h7;
  localparam logic [2:0]  CSD_SIZE_MULT     = 3'h7;
  localparam logic [4:0]  CSD_ERASE_SIZE    = 5'h1f;
  localparam logic [4:0]  CSD_ERASE_MULT    = 5'h1f;
  localparam logic [4:0]  CSD_PROTECT_SIZE  = 5'h0f;
  localparam logic [2:0]  CSD_WRITE_SPEED   = 3'h2;
  localparam logic [6:0]  CSD_CRC           = 7'h30;
  localparam logic [127:0] CSD_RESET =
    {STRUCTURE_VERSION_VER, CSD_SPEC_VER, 2'h0, CSD_ACCESS_NS, CSD_ACCESS_CLK, CSD_BUS_CLOCK,
     CSD_CMD_CLASSES, CSD_BLOCK_LEN, 4'h0, 2'h0, CSD_DEVICE_SIZE,
     {4{CSD_CURRENT_CODE}}, CSD_SIZE_MULT, CSD_ERASE_SIZE, CSD_ERASE_MULT, CSD_PROTECT_SIZE,
     1'b1, 2'h0, CSD_WRITE_SPEED, CSD_BLOCK_LEN, 1'b0, 4'h0, 5'h00, 2'h0, 2'h0,
     CSD_CRC, 1'b1};

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {ST_WAIT, ST_LOAD, ST_CRC, ST_SEAL, ST_DONE} cimr_state_t;

  // ****************************************************************
  // Checksum helpers, polynomial x^7 + x^3 + 1
  // ****************************************************************
  function automatic logic [6:0] cimr_crc7_step(input logic [6:0] crc, input logic din);
    logic fb;
    fb = din ^ crc[6];
    cimr_crc7_step = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
  endfunction : cimr_crc7_step

  function automatic logic [6:0] cimr_crc7_of(input logic [119:0] body);
    logic [6:0] crc;
    crc = 7'h00;
    for (int i = 119; i >= 0; i--)
    begin
      crc = cimr_crc7_step(crc, body[i]);
    end
    cimr_crc7_of = crc;
  endfunction : cimr_crc7_of

endpackage : cimr_pkg

`default_nettype wire

//--- core/cimr_regs.sv
// Read-only card registers: operating conditions, identification, card-specific data.
// Assumes serial number and date straps are static pins outside the clock domain,
// and that the command-line logic elsewhere reads the three words from the outputs.
`default_nettype none

module cimr_regs
  import cimr_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [31:0]  serial_number_in,
  input  wire logic [7:0]   manufacture_date_in,
  output logic      [31:0]  ocr_out,
  output logic      [127:0] cid_out,
  output logic      [127:0] csd_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    cimr_state_t        state;
    logic [TIMER_W-1:0] timer;
    logic [6:0]         bit_idx;
    logic [31:0]        sn_meta;
    logic [31:0]        sn_sync;
    logic [7:0]         dt_meta;
    logic [7:0]         dt_sync;
    logic [31:0]        operating_conditions;
    logic [127:0]       card_identification;
    logic [127:0]       card_specific_data;
  } cimr_regs_t;

  cimr_regs_t st_reg;
  cimr_regs_t st_next;

  logic [6:0] crc_val;
  logic       crc_clear;
  logic       crc_shift;
  logic       crc_bit;

  // ****************************************************************
  // Checksum engine
  // ****************************************************************
  cimr_crc7 u_crc7 (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .clear_in  (crc_clear),
    .shift_in  (crc_shift),
    .bit_in    (crc_bit),
    .crc_out   (crc_val)
  );

  assign crc_clear = (st_reg.state == ST_LOAD);
  assign crc_shift = (st_reg.state == ST_CRC);
  assign crc_bit   = st_reg.card_identification[7'(127) - st_reg.bit_idx];

  // ****************************************************************
  // Power-up sequencer
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    // Straps cross in through two stages; only the second is used
    st_next.sn_meta = serial_number_in;
    st_next.sn_sync = st_reg.sn_meta;
    st_next.dt_meta = manufacture_date_in;
    st_next.dt_sync = st_reg.dt_meta;
    unique case (st_reg.state)
      ST_WAIT:
      begin
        // Long enough for the strap synchronisers to settle before capture
        if (st_reg.timer == POWERUP_CYC - TIMER_W'(1))
        begin
          st_next.state = ST_LOAD;
        end
        else
        begin
          st_next.timer = st_reg.timer + TIMER_W'(1);
        end
      end
      ST_LOAD:
      begin
        st_next.card_identification[47:16] = st_reg.sn_sync;
        st_next.card_identification[15:8]  = st_reg.dt_sync;
        st_next.bit_idx    = 7'h00;
        st_next.state      = ST_CRC;
      end
      ST_CRC:
      begin
        if (st_reg.bit_idx == CID_LAST_IDX)
        begin
          st_next.state = ST_SEAL;
        end
        else
        begin
          st_next.bit_idx = st_reg.bit_idx + 7'h01;
        end
      end
      ST_SEAL:
      begin
        st_next.card_identification[7:1]            = crc_val;
        st_next.card_identification[0]              = 1'b1;
        st_next.operating_conditions[OCR_BUSY_BIT]   = 1'b1;
        st_next.state               = ST_DONE;
      end
      ST_DONE:
      begin
        st_next.state = ST_DONE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg       <= '0;
      st_reg.state <= ST_WAIT;
      st_reg.operating_conditions   <= OCR_RESET;
      st_reg.card_identification   <= CID_RESET;
      // Card-specific word is held in flops so a later revision may vary it
      st_reg.card_specific_data   <= CSD_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Sequencer checks
  // ****************************************************************
  // The checksum walk must visit every body bit once, in order, with no gaps
  load_step_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state == ST_LOAD) |=> (st_reg.state == ST_CRC) && (st_reg.bit_idx == 7'h00))
    else $error("checksum walk did not start at the top bit");

  wait_bound_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state == ST_WAIT) |-> (st_reg.timer < POWERUP_CYC))
    else $error("power-up timer ran past its limit");

  crc_walk_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state == ST_CRC) && (st_reg.bit_idx != CID_LAST_IDX) |=>
      (st_reg.state == ST_CRC) && (st_reg.bit_idx == $past(st_reg.bit_idx) + 7'h01))
    else $error("checksum walk skipped or left early");

  crc_end_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state == ST_CRC) && (st_reg.bit_idx == CID_LAST_IDX)
      |=> (st_reg.state == ST_SEAL))
    else $error("checksum walk overran the body");

  // Serial and date may only move at the capture step; later strap noise is ignored
  strap_hold_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state != ST_LOAD) |=> $stable(cid_out[47:8]))
    else $error("serial or date changed outside capture");

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ocr_out = st_reg.operating_conditions;
  assign cid_out = st_reg.card_identification;
  assign csd_out = st_reg.card_specific_data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int          BUSY_EDGE_INT = POWERUP_CYC_INT + CID_BODY_BITS + 2;
  localparam logic [15:0] BUSY_EDGE     = 16'(BUSY_EDGE_INT);

  // Edges since reset release, saturating once the busy bit is due
  logic [15:0] age_reg;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      age_reg <= 16'h0000;
    end
    else if (age_reg != BUSY_EDGE)
    begin
      age_reg <= age_reg + 16'h0001;
    end
  end

  busy_early_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (age_reg < BUSY_EDGE) |-> !ocr_out[OCR_BUSY_BIT])
    else $error("busy bit set before power-up routine ended");

  busy_done_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (age_reg == BUSY_EDGE) |-> ocr_out[OCR_BUSY_BIT] && (st_reg.state == ST_DONE))
    else $error("busy bit not set when power-up routine ended");

  busy_hold_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    $rose(ocr_out[OCR_BUSY_BIT]) |=> ocr_out[OCR_BUSY_BIT] [*4])
    else $error("busy bit dropped after power-up");

  busy_state_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    ocr_out[OCR_BUSY_BIT] |-> (st_reg.state == ST_DONE))
    else $error("busy bit high before routine finished");

  // ****************************************************************
  // Operating-conditions checks
  // ****************************************************************
  ocr_mode_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ocr_out[30:29] == 2'h2) && (ocr_out[28:24] == 5'h00))
    else $error("access mode or reserved bits wrong");

  ocr_voltage_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (ocr_out[23:15] == 9'h1ff) && (ocr_out[14:8] == 7'h00) && ocr_out[7]
    && (ocr_out[6:0] == 7'h00))
    else $error("voltage window bits wrong");

  ocr_still_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    $stable(ocr_out[30:0]))
    else $error("fixed operating-conditions bits moved");

  // ****************************************************************
  // Identification checks
  // ****************************************************************
  cid_capture_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (st_reg.state == ST_LOAD) |=>
      (cid_out[47:16] == $past(st_reg.sn_sync)) && (cid_out[15:8] == $past(st_reg.dt_sync))
      && (cid_out[127:120] == CID_MAKER_CODE) && (cid_out[113:112] == CID_PACKAGE_TYPE)
      && (cid_out[111:104] == CID_OEM_CODE) && (cid_out[103:56] == CID_PRODUCT_NAME)
      && (cid_out[55:48] == CID_PRODUCT_REV))
    else $error("identification fields wrong after capture");

  cid_crc_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    $rose(ocr_out[OCR_BUSY_BIT]) |->
      (cid_out[7:1] == cimr_crc7_of(cid_out[127:8])) && cid_out[0])
    else $error("identification checksum wrong");

  cid_stand_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    ocr_out[OCR_BUSY_BIT] && $past(ocr_out[OCR_BUSY_BIT]) |-> $stable(cid_out))
    else $error("identification word moved after power-up");

  cid_fixed_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (cid_out[119:114] == 6'h00) && cid_out[0])
    else $error("identification reserved or end bit wrong");

  // ****************************************************************
  // Card-specific checks
  // ****************************************************************
  csd_head_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (csd_out[127:126] == 2'h3) && (csd_out[125:122] == 4'h4)
    && (csd_out[119:112] == 8'h4f) && (csd_out[111:104] == CSD_ACCESS_CLK)
    && (csd_out[103:96] == 8'h32))
    else $error("card-specific version or timing wrong");

  csd_block_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (csd_out[83:80] == 4'h9) && (csd_out[25:22] == 4'h9) && (csd_out[79:77] == 3'h0)
    && !csd_out[21] && (csd_out[28:26] == 3'h2) && (csd_out[95:84] == 12'h0f5))
    else $error("block length, speed factor or classes wrong");

  csd_size_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    (csd_out[73:62] == 12'hfff) && (csd_out[61:50] == 12'hfff) && (csd_out[49:47] == 3'h7)
    && (csd_out[46:42] == 5'h1f) && (csd_out[41:37] == 5'h1f) && (csd_out[36:32] == 5'h0f))
    else $error("size, current or group fields wrong");

  csd_tail_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    csd_out[31] && (csd_out[14:12] == 3'h0) && (csd_out[7:1] == 7'h30) && csd_out[0])
    else $error("protect flags or card-specific checksum wrong");

  // Fixed in this build only; hosts are told not to rely on these values
  csd_still_a: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    $stable(csd_out))
    else $error("card-specific word moved");

endmodule : cimr_regs

`default_nettype wire

//--- verif/card_identity_config_regs_tb.sv
// Self-checking bench for the card register bank and a polling host model.
// Assumes straps stay stable through power-up and the 200 MHz clock is the only one.
`default_nettype none

module card_identity_config_regs_tb
  import cimr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         mclk_in;
  logic         arst_n_in;
  logic [31:0]  serial_number;
  logic [7:0]   manufacture_date;
  logic [31:0]  operating_conditions;
  logic [127:0] card_identification;
  logic [127:0] card_specific_data;
  logic         host_ready;
  logic [127:0] host_cid;
  int           fails;
  int           tests_run;

  // {word 0 = operating conditions / 1 = card data, msb, lsb, value}
  int tab [27][4] = '{
    '{0, 30, 29, 2}, '{0, 28, 24, 0}, '{0, 23, 15, 'h1ff}, '{0, 14, 8, 0},
    '{0, 7, 7, 1}, '{0, 6, 0, 0}, '{1, 127, 126, 3}, '{1, 125, 122, 4},
    '{1, 119, 112, 'h4f}, '{1, 103, 96, 'h32}, '{1, 95, 84, 'hf5}, '{1, 83, 80, 9},
    '{1, 79, 77, 0}, '{1, 73, 62, 'hfff}, '{1, 61, 50, 'hfff}, '{1, 49, 47, 7},
    '{1, 46, 42, 'h1f}, '{1, 41, 37, 'h1f}, '{1, 36, 32, 'h0f}, '{1, 31, 31, 1},
    '{1, 28, 26, 2}, '{1, 25, 22, 9}, '{1, 21, 21, 0}, '{1, 14, 12, 0},
    '{1, 7, 1, 'h30}, '{1, 0, 0, 1}, '{1, 111, 104, 1}};

  cimr_regs cimr_regs_i (
    .mclk_in             (mclk_in),
    .arst_n_in           (arst_n_in),
    .serial_number_in    (serial_number),
    .manufacture_date_in (manufacture_date),
    .ocr_out             (operating_conditions),
    .cid_out             (card_identification),
    .csd_out             (card_specific_data)
  );

  cimr_host_model cimr_host_model_i (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .ocr_in       (operating_conditions),
    .cid_in       (card_identification),
    .ready_out    (host_ready),
    .cid_seen_out (host_cid)
  );

  always #2.5 mclk_in = ~mclk_in;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  function automatic logic [6:0] crc7_calc(input logic [119:0] b);
    logic [6:0] c;
    logic       f;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
    begin
      f = b[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7_calc

  task automatic end_sim();
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Busy must still be low one edge before the routine ends, then rise within a few edges
  task automatic boot_and_check();
    logic [119:0] body;
    logic [127:0] fld;
    chk(128'(operating_conditions), 128'h40ff8080, "reset word");
    chk(128'(card_identification[47:0]), 128'h1, "cid low bits in reset");
    repeat (POWERUP_CYC_INT + CID_BODY_BITS + 1) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(128'(operating_conditions[31]), 128'h0, "busy rose early");
    chk(128'(host_ready), 128'h0, "host read before busy");
    for (int i = 0; i < 4 && operating_conditions[31] !== 1'b1; i++) @(negedge mclk_in);
    chk(128'(operating_conditions[31]), 128'h1, "busy never rose");
    for (int r = 0; r < 27; r++)
    begin
      fld = ((tab[r][0] != 0) ? card_specific_data : 128'(operating_conditions)) >> tab[r][2];
      fld = fld & ((128'h1 << (tab[r][1] - tab[r][2] + 1)) - 128'h1);
      chk(fld, 128'(tab[r][3]), $sformatf("row %0d", r));
    end
    body = {CID_MAKER_CODE, 6'h00, CID_PACKAGE_TYPE, CID_OEM_CODE, CID_PRODUCT_NAME,
            CID_PRODUCT_REV, serial_number, manufacture_date};
    chk(128'(card_identification[127:8]), 128'(body), "cid fields");
    chk(128'(card_identification[7:0]), 128'({crc7_calc(body), 1'b1}), "cid checksum");
    @(negedge mclk_in);
    chk(128'(host_ready), 128'h1, "host not ready");
    chk(host_cid, {body, crc7_calc(body), 1'b1}, "host capture");
  endtask : boot_and_check

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    mclk_in          = 1'b0;
    arst_n_in        = 1'b0;
    fails            = 0;
    tests_run        = 0;
    serial_number    = 32'h8e2b_14c7;
    manufacture_date = 8'ha3;
    repeat (6) @(negedge mclk_in);
    arst_n_in = 1'b1;
    boot_and_check();
    // Straps moved after capture must not reach the word
    serial_number    = 32'h7154_eb39;
    manufacture_date = 8'h5c;
    repeat (10) @(negedge mclk_in);
    chk(128'(card_identification[47:8]), 128'h8e2b14c7a3, "late strap taken");
    // Second reset in mid-run, then another three quarters into a fresh power-up wait
    arst_n_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    chk(128'(operating_conditions), 128'h40ff8080, "busy kept through reset");
    chk(128'(card_identification[47:0]), 128'h1, "cid kept through reset");
    chk(128'(host_ready), 128'h0, "host kept ready through reset");
    arst_n_in = 1'b1;
    repeat (150) @(negedge mclk_in);
    chk(128'(operating_conditions[31]), 128'h0, "busy early after reset");
    arst_n_in = 1'b0;
    @(negedge mclk_in);
    arst_n_in = 1'b1;
    boot_and_check();
    end_sim();
  end

  // Two boots of about 330 cycles each plus margin
  initial
  begin
    #(5 * 3000);
    fails++;
    end_sim();
  end
endmodule : card_identity_config_regs_tb

`default_nettype wire

//--- verif/cimr_host_model.sv
// Behavioural host controller on the far side of the card register bank.
// Assumes the two words are static levels sampled on the rising clock edge.
`default_nettype none

module cimr_host_model
(
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [31:0]  ocr_in,
  input  wire logic [127:0] cid_in,
  output logic              ready_out,
  output logic      [127:0] cid_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Identification is only taken once busy reads high; earlier it is incomplete
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ready_out    <= 1'b0;
      cid_seen_out <= '0;
    end
    else if (!ready_out && ocr_in[31])
    begin
      ready_out    <= 1'b1;
      cid_seen_out <= cid_in;
    end
  end
endmodule : cimr_host_model

`default_nettype wire
